// [djs_jog_cds.sv]
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "djs_cfg.svh"
module djs_jog_cds #(
    parameter int MS_CYCLES = `DJS_MS_CYCLES
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic SYS_RST_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Digital input pins
    input wire logic [7:0] DI_IN,
    // Drive control
    input wire logic READY_IN,
    input wire logic ON_IN,
    // Setpoint sources
    input djs_pkg::djs_speed_t AI0_IN,
    input djs_pkg::djs_speed_t FIELDBUS_IN,
    input djs_pkg::djs_speed_t MOP_IN,
    input djs_pkg::djs_speed_t FIXED_IN,
    // Overriding sources
    input wire logic TECH_ACTIVE_IN,
    input djs_pkg::djs_speed_t TECH_SPEED_IN,
    input wire logic PANEL_ACTIVE_IN,
    input djs_pkg::djs_speed_t PANEL_SPEED_IN,
    // Drive outputs
    output djs_pkg::djs_speed_t SPEED_SETPOINT_OUT,
    output logic MOTOR_ON_OUT,
    output logic JOG_ACTIVE_OUT,
    output logic [1:0] ACTIVE_SET_OUT
);
    import djs_pkg::*;
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    djs_state_t st_reg, st_next;
    djs_speed_t ramp_speed;
    logic [11:0] mem_rdata;
    logic mem_we;
    logic [1:0] mem_waddr;
    logic [11:0] mem_wdata;
    logic [1:0] mem_raddr;
    logic j0, j1, jog_ok;
    logic [1:0] cds_sel;

    function automatic djs_speed_t pick_src(input logic [1:0] code);
        case (code)
            `DJS_SRC_AI0: pick_src = AI0_IN;
            `DJS_SRC_FB: pick_src = FIELDBUS_IN;
            `DJS_SRC_MOP: pick_src = MOP_IN;
            default: pick_src = FIXED_IN;
        endcase
    endfunction

    djs_set_mem u_mem (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .we_in(mem_we),
        .waddr_in(mem_waddr),
        .wdata_in(mem_wdata),
        .raddr_in(mem_raddr),
        .rdata_out(mem_rdata)
    );

    djs_ramp u_ramp (
        .clk_in(MCLK_IN),
        .rst_in(SYS_RST_IN),
        .ms_tick_in(st_reg.ms_tick),
        .target_in(st_reg.target),
        .max_spd_in(st_reg.max_spd),
        .up_ms_in(st_reg.up_ms),
        .dn_ms_in(st_reg.dn_ms),
        .speed_out(ramp_speed)
    );

    always_comb begin
        logic acc_cyc, wr;
        logic signed [17:0] raw;
        logic signed [17:0] lim;
        logic [31:0] rd;
        logic bad;
        acc_cyc = PSEL_IN && PENABLE_IN && st_reg.pready;
        wr = acc_cyc && PWRITE_IN;
        raw = '0;
        lim = $signed({2'b00, st_reg.max_spd});
        rd = '0;
        bad = 1'b0;
        st_next = st_reg;
        mem_we = 1'b0;
        mem_waddr = st_reg.cp_tgt;
        mem_wdata = mem_rdata;

        // Pins pass three flops; a level counts once stages two and three agree
        st_next.di_s1 = DI_IN;
        st_next.di_s2 = st_reg.di_s1;
        st_next.di_s3 = st_reg.di_s2;
        st_next.di_st = (~(st_reg.di_s2 ^ st_reg.di_s3) & st_reg.di_s2) |
                        ((st_reg.di_s2 ^ st_reg.di_s3) & st_reg.di_st);

        st_next.ms_tick = (st_reg.ms_cnt == MS_LAST);
        st_next.ms_cnt = st_next.ms_tick ? 16'h0000 : st_reg.ms_cnt + 16'h0001;

        // APB: one wait state, answer held in registers
        st_next.pready = PSEL_IN && PENABLE_IN && !st_reg.pready;
        case (PADDR_IN)
            `DJS_A_JOG1: rd = {{16{st_reg.jog1[15]}}, st_reg.jog1};
            `DJS_A_JOG2: rd = {{16{st_reg.jog2[15]}}, st_reg.jog2};
            `DJS_A_MAX: rd = {16'h0000, st_reg.max_spd};
            `DJS_A_CTRL: rd = {29'h0, st_reg.invert, st_reg.pos_inh, st_reg.neg_inh};
            `DJS_A_RUP: rd = {16'h0000, st_reg.up_ms};
            `DJS_A_RDN: rd = {16'h0000, st_reg.dn_ms};
            `DJS_A_CDSCFG: rd = {24'h0, st_reg.comm, 1'b0, st_reg.cnt};
            `DJS_A_CDSSEL: rd = {25'h0, st_reg.cds_src1, 1'b0, st_reg.cds_src0};
            `DJS_A_COPY: rd = {23'h0, st_reg.cp_start, 2'h0, st_reg.cp_tgt, 2'h0,
                               st_reg.cp_src};
            `DJS_A_SETDATA: rd = {20'h0, st_reg.set_word};
            `DJS_A_STATUS: rd = {19'h0, st_reg.jog_on, st_reg.motor_on, 1'b0,
                                 st_reg.mode, 2'h0, st_reg.cp_st != DJS_CP_IDLE,
                                 st_reg.switching, 2'h0, st_reg.active};
            `DJS_A_SPEED: rd = {{16{ramp_speed[15]}}, ramp_speed};
            default: bad = 1'b1;
        endcase
        if (st_next.pready) begin
            st_next.prdata = PWRITE_IN ? 32'h0 : rd;
            st_next.pslverr = bad || (PWRITE_IN && (PADDR_IN == `DJS_A_SETDATA) &&
                                      (st_reg.cp_st != DJS_CP_IDLE));
        end
        if (wr) begin
            case (PADDR_IN)
                `DJS_A_JOG1: st_next.jog1 = PWDATA_IN[15:0];
                `DJS_A_JOG2: st_next.jog2 = PWDATA_IN[15:0];
                `DJS_A_MAX: st_next.max_spd = PWDATA_IN[15:0];
                `DJS_A_CTRL: begin
                    st_next.neg_inh = PWDATA_IN[`DJS_CTRL_NEG];
                    st_next.pos_inh = PWDATA_IN[`DJS_CTRL_POS];
                    st_next.invert = PWDATA_IN[`DJS_CTRL_INV];
                end
                `DJS_A_RUP: st_next.up_ms = PWDATA_IN[15:0];
                `DJS_A_RDN: st_next.dn_ms = PWDATA_IN[15:0];
                `DJS_A_CDSCFG: begin
                    st_next.comm = PWDATA_IN[`DJS_CFG_COMM];
                    // Count only changes in data-set commissioning
                    if (st_reg.comm == `DJS_COMM_SETS &&
                        PWDATA_IN[`DJS_CFG_CNT] >= `DJS_CNT_MIN &&
                        PWDATA_IN[`DJS_CFG_CNT] <= `DJS_CNT_MAX) begin
                        st_next.cnt = PWDATA_IN[`DJS_CFG_CNT];
                    end
                end
                `DJS_A_CDSSEL: begin
                    st_next.cds_src0 = PWDATA_IN[`DJS_SEL_B0];
                    st_next.cds_src1 = PWDATA_IN[`DJS_SEL_B1];
                end
                `DJS_A_COPY: begin
                    st_next.cp_src = PWDATA_IN[`DJS_CP_SRC];
                    st_next.cp_tgt = PWDATA_IN[`DJS_CP_TGT];
                end
                `DJS_A_SETDATA: begin
                    if (st_reg.cp_st == DJS_CP_IDLE) begin
                        mem_we = 1'b1;
                        mem_waddr = PWDATA_IN[`DJS_SD_IDX];
                        mem_wdata = PWDATA_IN[`DJS_SD_WORD];
                    end
                end
                default: ;
            endcase
        end

        // Set copy: read source, write target, then drop the start bit
        case (st_reg.cp_st)
            DJS_CP_IDLE: begin
                if (st_reg.cp_start) begin
                    st_next.cp_st = DJS_CP_READ;
                end
            end
            DJS_CP_READ: st_next.cp_st = DJS_CP_WRITE;
            DJS_CP_WRITE: begin
                mem_we = 1'b1;
                mem_waddr = st_reg.cp_tgt;
                mem_wdata = mem_rdata;
                st_next.cp_start = 1'b0;
                st_next.cp_st = DJS_CP_IDLE;
            end
            default: st_next.cp_st = DJS_CP_IDLE;
        endcase
        // A software start in the finishing cycle is kept, not lost
        if (wr && PADDR_IN == `DJS_A_COPY && PWDATA_IN[`DJS_CP_START]) begin
            st_next.cp_start = 1'b1;
        end

        // Working copy of the active set only follows reads of the active set
        mem_raddr = (st_reg.cp_st == DJS_CP_IDLE && !st_reg.cp_start) ?
                    st_reg.active : st_reg.cp_src;
        st_next.rd_act = (mem_raddr == st_reg.active) && !st_reg.switching;
        if (st_reg.rd_act && st_reg.cp_st == DJS_CP_IDLE && !st_reg.cp_start) begin
            st_next.set_word = mem_rdata;
        end

        // Set switch after a settle time; out-of-range selections are ignored
        if (cds_sel != st_reg.active && {1'b0, cds_sel} < st_reg.cnt) begin
            if (!st_reg.switching || cds_sel != st_reg.pend) begin
                st_next.switching = 1'b1;
                st_next.pend = cds_sel;
                st_next.sw_cnt = '0;
            end else if (st_reg.ms_tick && st_reg.cp_st == DJS_CP_IDLE) begin
                if (st_reg.sw_cnt == `DJS_SWITCH_MS - 3'h1) begin
                    st_next.active = st_reg.pend;
                    st_next.switching = 1'b0;
                end else begin
                    st_next.sw_cnt = st_reg.sw_cnt + 3'h1;
                end
            end
        end else begin
            st_next.switching = 1'b0;
        end

        // Operating mode
        case (st_reg.mode)
            DJS_OFF: begin
                if (READY_IN && jog_ok) begin
                    st_next.mode = DJS_JOG;
                end else if (READY_IN && ON_IN && !(j0 || j1)) begin
                    st_next.mode = DJS_RUN;
                end
            end
            DJS_JOG: begin
                if (!jog_ok) begin
                    st_next.mode = DJS_STOP;
                end
            end
            DJS_RUN: begin
                if (!ON_IN) begin
                    st_next.mode = DJS_STOP;
                end
            end
            DJS_STOP: begin
                if (ramp_speed == 16'sh0000 && st_reg.target == 16'sh0000) begin
                    st_next.mode = DJS_OFF;
                end
            end
            default: st_next.mode = DJS_OFF;
        endcase
        st_next.motor_on = (st_next.mode != DJS_OFF);
        st_next.jog_on = (st_next.mode == DJS_JOG);

        // Setpoint selection and conditioning
        case (st_reg.mode)
            DJS_JOG: raw = j0 ? 18'(st_reg.jog1) : 18'(st_reg.jog2);
            DJS_RUN: begin
                if (TECH_ACTIVE_IN) begin
                    raw = 18'(TECH_SPEED_IN);
                end else if (PANEL_ACTIVE_IN) begin
                    raw = 18'(PANEL_SPEED_IN);
                end else begin
                    raw = 18'(pick_src(st_reg.set_word[`DJS_SW_MAIN])) +
                          18'(pick_src(st_reg.set_word[`DJS_SW_ADD]));
                end
            end
            default: raw = '0;
        endcase
        if (st_reg.invert) begin
            raw = -raw;
        end
        if (raw > lim) begin
            raw = lim;
        end else if (raw < -lim) begin
            raw = -lim;
        end
        if (st_reg.neg_inh && raw < 0) begin
            raw = '0;
        end
        if (st_reg.pos_inh && raw > 0) begin
            raw = '0;
        end
        st_next.target = raw[15:0];
    end

    assign j0 = st_reg.di_st[st_reg.set_word[`DJS_SW_J0]];
    assign j1 = st_reg.di_st[st_reg.set_word[`DJS_SW_J1]];
    assign jog_ok = j0 ^ j1;
    assign cds_sel = {st_reg.di_st[st_reg.cds_src1], st_reg.di_st[st_reg.cds_src0]};

    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            st_reg <= '0;
            st_reg.jog1 <= `DJS_JOG1_RST;
            st_reg.jog2 <= `DJS_JOG2_RST;
            st_reg.max_spd <= `DJS_MAX_RST;
            st_reg.up_ms <= `DJS_RAMP_RST;
            st_reg.dn_ms <= `DJS_RAMP_RST;
            st_reg.cnt <= `DJS_CNT_RST;
            st_reg.cds_src0 <= `DJS_CDS_SRC0_RST;
            st_reg.cds_src1 <= `DJS_CDS_SRC1_RST;
            st_reg.set_word <= `DJS_SET_RST;
            st_reg.cp_st <= DJS_CP_IDLE;
            st_reg.mode <= DJS_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA_OUT = st_reg.prdata;
    assign PREADY_OUT = st_reg.pready;
    assign PSLVERR_OUT = st_reg.pslverr;
    assign SPEED_SETPOINT_OUT = ramp_speed;
    assign MOTOR_ON_OUT = st_reg.motor_on;
    assign JOG_ACTIVE_OUT = st_reg.jog_on;
    assign ACTIVE_SET_OUT = st_reg.active;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_copy_req;
        st_reg.cp_start && st_reg.cp_st == DJS_CP_IDLE;
    endsequence
    sequence s_copy_done;
        ##[1:3] !st_reg.cp_start;
    endsequence

    AST_JOG_RELEASE_STOPS: assert property (
        st_reg.mode == DJS_JOG && !jog_ok |=> st_reg.mode == DJS_STOP)
        else $error("jog release did not stop the motor");
    AST_JOG_NOT_WHILE_RUN: assert property (
        st_reg.mode == DJS_RUN |=> st_reg.mode != DJS_JOG)
        else $error("jog taken while running");
    AST_JOG_NEEDS_READY: assert property (
        st_reg.mode == DJS_OFF && !READY_IN |=> st_reg.mode == DJS_OFF)
        else $error("drive left off without ready");
    AST_MAX_BOUND: assert property (
        $stable(st_reg.max_spd) |-> (st_reg.target <= $signed({1'b0, st_reg.max_spd[14:0]})
        || st_reg.max_spd[15]))
        else $error("setpoint above maximum speed");
    AST_NEG_BLOCK: assert property (
        $past(st_reg.neg_inh) && st_reg.neg_inh |-> st_reg.target >= 0)
        else $error("negative setpoint while inhibited");
    AST_POS_BLOCK: assert property (
        $past(st_reg.pos_inh) && st_reg.pos_inh |-> st_reg.target <= 0)
        else $error("positive setpoint while inhibited");
    AST_BOTH_JOG_OFF: assert property (
        st_reg.mode == DJS_OFF && j0 && j1 |=> st_reg.mode != DJS_JOG)
        else $error("jog taken with both select bits");
    AST_COPY_FINISHES: assert property (
        s_copy_req |-> s_copy_done)
        else $error("copy start not cleared");
    AST_SWITCH_HOLDS_SET: assert property (
        st_reg.switching && !(st_reg.ms_tick) |=> $stable(st_reg.active))
        else $error("active set changed before switch time");
endmodule

// [djs_cfg.svh]
`ifndef DJS_CFG_SVH
`define DJS_CFG_SVH
// Behaviour
// - Jog command switches motor on toward jog speed; removing it ramps to stop.
// - Two jog speed setpoints, reset values 150 rpm and -150 rpm.
// - Jog uses the normal ramp generator; ramp up and down reset to 10 s.
// - Jog accepted only when ready to start; ignored while motor runs.
// - Configurable maximum speed, reset 1500 rpm, bounds the applied setpoint.
// - Negative inhibit at 1 blocks negative rotation; at 0 permits it.
// - Positive inhibit at 1 blocks positive rotation; at 0 permits it.
// - Inversion at 1 negates the setpoint; at 0 passes it unchanged.
// - Two jog select bits from selectable digital inputs, default inputs 0 and 1.
// - Active command set index formed from two selectable source bits.
// - Switch to a newly selected command set completes in about 4 ms.
// - Index of active command set readable as read-only status.
// - Copy source set to target on start bit; start clears when finished.
// - Main and additional setpoint from analog, fieldbus, potentiometer or fixed.
// - Source code 0 selects analog input 0 for main or additional.
// - Jog, technology controller or panel replaces the sum of main and additional setpoint.

`define DJS_CLK_HZ 50000000
`define DJS_MS_PER_S 1000
`define DJS_MS_CYCLES (`DJS_CLK_HZ / `DJS_MS_PER_S)
`define DJS_SWITCH_MS 3'h4
`define DJS_JOG1_RST 16'h0096
`define DJS_JOG2_RST 16'hFF6A
`define DJS_MAX_RST 16'h05DC
`define DJS_RAMP_S 10
`define DJS_RAMP_RST (16'(`DJS_RAMP_S * `DJS_MS_PER_S))
`define DJS_CNT_RST 3'h2
`define DJS_CNT_MIN 3'h2
`define DJS_CNT_MAX 3'h4
`define DJS_COMM_SETS 4'hF
`define DJS_CDS_SRC0_RST 3'h2
`define DJS_CDS_SRC1_RST 3'h3
`define DJS_SET_RST 12'h010

// APB byte offsets
`define DJS_A_JOG1 8'h00
`define DJS_A_JOG2 8'h04
`define DJS_A_MAX 8'h08
`define DJS_A_CTRL 8'h0C
`define DJS_A_RUP 8'h10
`define DJS_A_RDN 8'h14
`define DJS_A_CDSCFG 8'h18
`define DJS_A_CDSSEL 8'h1C
`define DJS_A_COPY 8'h20
`define DJS_A_SETDATA 8'h24
`define DJS_A_STATUS 8'h28
`define DJS_A_SPEED 8'h2C

// Field positions
`define DJS_CTRL_NEG 0
`define DJS_CTRL_POS 1
`define DJS_CTRL_INV 2
`define DJS_CFG_CNT 2:0
`define DJS_CFG_COMM 7:4
`define DJS_SEL_B0 2:0
`define DJS_SEL_B1 6:4
`define DJS_CP_SRC 1:0
`define DJS_CP_TGT 5:4
`define DJS_CP_START 8
`define DJS_SD_WORD 11:0
`define DJS_SD_IDX 25:24
`define DJS_SW_J0 2:0
`define DJS_SW_J1 6:4
`define DJS_SW_MAIN 9:8
`define DJS_SW_ADD 11:10

// Setpoint source codes
`define DJS_SRC_AI0 2'h0
`define DJS_SRC_FB 2'h1
`define DJS_SRC_MOP 2'h2
`define DJS_SRC_FIX 2'h3
`endif

// [djs_pkg.sv]
package djs_pkg;
    typedef logic signed [15:0] djs_speed_t;
    typedef enum logic [1:0] {
        DJS_OFF = 2'b00, DJS_JOG = 2'b01, DJS_RUN = 2'b11, DJS_STOP = 2'b10
    } djs_mode_t;
    typedef enum logic [1:0] {
        DJS_CP_IDLE = 2'b00, DJS_CP_READ = 2'b01, DJS_CP_WRITE = 2'b11
    } djs_copy_t;
    typedef struct packed {
        logic [3:0][11:0] mem;
        logic [11:0] rdata;
    } djs_mem_state_t;
    typedef struct packed {
        djs_speed_t speed;
        logic [16:0] acc;
    } djs_ramp_state_t;
    typedef struct packed {
        logic [7:0] di_s1, di_s2, di_s3, di_st;
        logic pready, pslverr;
        logic [31:0] prdata;
        djs_speed_t jog1, jog2;
        logic [15:0] max_spd, up_ms, dn_ms;
        logic neg_inh, pos_inh, invert;
        logic [3:0] comm;
        logic [2:0] cnt, cds_src0, cds_src1;
        logic [1:0] cp_src, cp_tgt;
        logic cp_start;
        djs_copy_t cp_st;
        logic [1:0] active, pend;
        logic switching;
        logic [2:0] sw_cnt;
        logic rd_act;
        logic [11:0] set_word;
        logic [15:0] ms_cnt;
        logic ms_tick;
        djs_mode_t mode;
        djs_speed_t target;
        logic motor_on, jog_on;
    } djs_state_t;
endpackage

// [djs_set_mem.sv]
`timescale 1ns/1ps
`include "djs_cfg.svh"
module djs_set_mem (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Write port
    input wire logic we_in,
    input wire logic [1:0] waddr_in,
    input wire logic [11:0] wdata_in,
    // Registered read port
    input wire logic [1:0] raddr_in,
    output logic [11:0] rdata_out
);
    import djs_pkg::*;
    djs_mem_state_t st_reg, st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rdata = st_reg.mem[raddr_in];
        if (we_in) begin
            st_next.mem[waddr_in] = wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= {{4{`DJS_SET_RST}}, `DJS_SET_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata_out = st_reg.rdata;
endmodule

// [djs_ramp.sv]
`timescale 1ns/1ps
`include "djs_cfg.svh"
module djs_ramp (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Millisecond enable
    input wire logic ms_tick_in,
    // Settings
    input djs_pkg::djs_speed_t target_in,
    input wire logic [15:0] max_spd_in,
    input wire logic [15:0] up_ms_in,
    input wire logic [15:0] dn_ms_in,
    // Ramped speed
    output djs_pkg::djs_speed_t speed_out
);
    import djs_pkg::*;
    djs_ramp_state_t st_reg, st_next;

    // Ramp time spans zero to max speed: every ms max_spd is accumulated and
    // one rpm is stepped each time the ramp time in ms is used up.
    always_comb begin
        logic up;
        logic [16:0] sum;
        logic [16:0] span;
        st_next = st_reg;
        up = ((target_in > st_reg.speed) && (st_reg.speed >= 0)) ||
             ((target_in < st_reg.speed) && (st_reg.speed <= 0));
        span = {1'b0, up ? up_ms_in : dn_ms_in};
        sum = st_reg.acc + {1'b0, max_spd_in};
        if (target_in == st_reg.speed) begin
            st_next.acc = '0;
        end else if (ms_tick_in) begin
            if (sum >= span) begin
                st_next.acc = sum - span;
                st_next.speed = (target_in > st_reg.speed) ?
                    st_reg.speed + 16'sh0001 : st_reg.speed - 16'sh0001;
            end else begin
                st_next.acc = sum;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign speed_out = st_reg.speed;
endmodule

// [djs_ctrl_model.sv]
`timescale 1ns/1ps
module djs_ctrl_model (
    // Clock
    input wire logic clk_in,
    // APB master side
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [7:0] paddr_out,
    output logic [31:0] pwdata_out,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    // Digital input pins
    output logic [7:0] di_out
);
    initial begin
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        paddr_out = 8'h00;
        pwdata_out = 32'h0;
        di_out = 8'h00;
    end

    // Call right after a rising edge; request held until pready is sampled
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        psel_out <= 1'b1;
        pwrite_out <= wr;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready_in !== 1'b1);
        rd = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
        // Idle bus shows a changed pattern so stale values are never trusted
        paddr_out <= ~a;
        pwdata_out <= ~d;
        // Idle edge, so a following call never drives psel twice in one step
        @(posedge clk_in);
    endtask

    task automatic set_di(input logic [7:0] v);
        di_out <= v;
    endtask
endmodule

// [tb_drive_jog_and_command_set_select.sv]
`timescale 1ns/1ps
module tb_drive_jog_and_command_set_select;
    import djs_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, ready = 1'b0, on = 1'b0, tech = 1'b0, panel = 1'b0;
    djs_speed_t ai0 = 16'h0000, tspd = 16'h0000, fb = 16'h0000, mop = 16'h0000, spd, v;
    djs_speed_t fix = 16'h0000, pspd = 16'h0000;
    logic psel, pen, pwr, pready, perr, mon, jog, err;
    logic [7:0] paddr, di;
    logic [31:0] pwd, prd, rd;
    logic [1:0] aset;
    logic [2:0] ctab [4] = '{3'h0, 3'h4, 3'h1, 3'h6};
    int miscompares = 0, cmp_count = 0;

    always #10 mclk = ~mclk;

    djs_ctrl_model ctrl (.clk_in(mclk), .psel_out(psel), .penable_out(pen),
        .pwrite_out(pwr), .paddr_out(paddr), .pwdata_out(pwd), .prdata_in(prd),
        .pready_in(pready), .pslverr_in(perr), .di_out(di));

    djs_jog_cds #(.MS_CYCLES(10)) dut (.MCLK_IN(mclk), .SYS_RST_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd),
        .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(perr), .DI_IN(di),
        .READY_IN(ready), .ON_IN(on), .AI0_IN(ai0), .FIELDBUS_IN(fb),
        .MOP_IN(mop), .FIXED_IN(fix), .TECH_ACTIVE_IN(tech),
        .TECH_SPEED_IN(tspd), .PANEL_ACTIVE_IN(panel), .PANEL_SPEED_IN(pspd),
        .SPEED_SETPOINT_OUT(spd), .MOTOR_ON_OUT(mon), .JOG_ACTIVE_OUT(jog),
        .ACTIVE_SET_OUT(aset));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        ctrl.xfer(1'b0, a, 32'h0, rd, err);
        chk("register read", e & m, rd & m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ctrl.xfer(1'b1, a, d, rd, err);
        chk("write error flag", 32'h0, {31'h0, err});
    endtask

    // Sampled on the falling edge so clocked outputs have settled
    task automatic wait_for(input string nm, input int sel, input logic [15:0] e,
            input int lim);
        logic [15:0] g;
        for (int n = 0; n < lim; n++) begin
            @(negedge mclk);
            g = (sel == 0) ? spd : (sel == 1) ? {15'h0, mon} :
                (sel == 2) ? {14'h0, aset} : {15'h0, jog};
            if (g === e) break;
        end
        @(posedge mclk);
        chk(nm, {16'h0, e}, {16'h0, g});
    endtask

    function automatic djs_speed_t exp_spd(djs_speed_t s0, logic [2:0] c, djs_speed_t m);
        djs_speed_t s;
        s = c[2] ? -s0 : s0;
        if (s > m) s = m;
        if (s < -m) s = -m;
        if ((s < 0 && c[0]) || (s > 0 && c[1])) s = 16'h0000;
        return s;
    endfunction

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #1_800_000;
        miscompares++;
        stop_test();
    end

    initial begin
        void'($urandom(55));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdc(8'h00, 32'h96, 32'hFFFF);
        rdc(8'h04, 32'hFF6A, 32'hFFFF);
        rdc(8'h08, 32'h5DC, 32'hFFFF);
        rdc(8'h10, 32'h2710, 32'hFFFF);
        rdc(8'h14, 32'h2710, 32'hFFFF);
        rdc(8'h28, 32'h0, 32'h3);
        ctrl.xfer(1'b0, 8'h30, 32'h0, rd, err);
        chk("unmapped error flag", 32'h1, {31'h0, err});
        $display("test reset values done");
        // Short ramps keep the run brief; the clamp is set low to be reachable
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h1);
        wr(8'h08, 32'hC8);
        ready <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = 16'($urandom_range(600)) - 16'sd300;
            wr(8'h00, {16'h0, v});
            wr(8'h0C, {29'h0, ctab[i]});
            ctrl.set_di(8'h01);
            wait_for("jog active", 3, 16'h1, 20);
            wait_for("jog speed", 0, exp_spd(v, ctab[i], 16'sd200), 6000);
            ctrl.set_di(8'h00);
            wait_for("motor off", 1, 16'h0, 6000);
        end
        wr(8'h0C, 32'h0);
        ctrl.set_di(8'h02);
        wait_for("second jog speed", 0, 16'hFF6A, 6000);
        ctrl.set_di(8'h00);
        wait_for("motor off", 1, 16'h0, 6000);
        ctrl.set_di(8'h03);
        repeat (40) @(posedge mclk);
        wait_for("both bits motor", 1, 16'h0, 1);
        ctrl.set_di(8'h00);
        $display("test jog done");
        wr(8'h24, 32'hC10);
        ai0 <= 16'($urandom_range(300)) - 16'sd150;
        fix <= 16'($urandom_range(100)) - 16'sd50;
        mop <= 16'($urandom_range(100));
        fb <= 16'($urandom_range(100)) - 16'sd100;
        on <= 1'b1;
        @(posedge mclk);
        wait_for("main speed", 0, exp_spd(ai0 + fix, 3'h0, 16'sd200), 6000);
        ctrl.set_di(8'h01);
        repeat (30) @(posedge mclk);
        wait_for("jog while running", 3, 16'h0, 1);
        ctrl.set_di(8'h00);
        wr(8'h24, 32'h610);
        wait_for("mop plus fieldbus", 0, exp_spd(mop + fb, 3'h0, 16'sd200), 6000);
        v = 16'($urandom_range(120)) + 16'sd10;
        panel <= 1'b1;
        pspd <= v;
        wait_for("panel speed", 0, v, 6000);
        // Panel stays on: the technology controller must win over it
        tech <= 1'b1;
        tspd <= -16'sd40;
        wait_for("override speed", 0, 16'hFFD8, 6000);
        tech <= 1'b0;
        panel <= 1'b0;
        on <= 1'b0;
        wait_for("motor off", 1, 16'h0, 6000);
        $display("test setpoint source done");
        ctrl.set_di(8'h04);
        repeat (20) @(posedge mclk);
        wait_for("set held", 2, 16'h0, 1);
        wait_for("set switched", 2, 16'h1, 80);
        rdc(8'h28, 32'h1, 32'h3);
        ctrl.set_di(8'h0C);
        repeat (80) @(posedge mclk);
        wait_for("set out of range", 2, 16'h1, 1);
        wr(8'h18, 32'hF2);
        wr(8'h18, 32'hF4);
        wr(8'h18, 32'h04);
        wait_for("set three", 2, 16'h3, 80);
        wr(8'h20, 32'h130);
        for (int n = 0; n < 20; n++) begin
            ctrl.xfer(1'b0, 8'h20, 32'h0, rd, err);
            if (rd[8] === 1'b0) break;
        end
        chk("copy start cleared", 32'h0, {31'h0, rd[8]});
        repeat (10) @(posedge mclk);
        rdc(8'h24, 32'h610, 32'hFFF);
        $display("test command sets done");
        stop_test();
    end
endmodule
